/* File: tbcu_pkg.sv */
// Constants and types of the transmit buffer command unpacker
package tbcu_pkg;
    // ==========================================================
    // Register map (byte addresses, one word each)
    localparam logic [3:0] TBCU_ADDR_DATA = 4'h0;
    localparam logic [3:0] TBCU_ADDR_STAT = 4'h4;
    localparam logic [3:0] TBCU_ADDR_TXST = 4'h8;
    localparam logic [3:0] TBCU_ADDR_SUM = 4'hC;
    localparam int TBCU_STAT_ERR = 0;
    localparam int TBCU_STAT_ST_LO = 4;
    // ==========================================================
    // First command word fields
    localparam int TBCU_A_ALIGN_LO = 24;
    localparam int TBCU_A_OFF_LO = 16;
    localparam int TBCU_A_FS = 13;
    localparam int TBCU_A_LS = 12;
    // ==========================================================
    // Second command word fields
    localparam int TBCU_B_TAG_LO = 16;
    localparam int TBCU_B_CRC_DIS = 13;
    localparam int TBCU_B_PAD_DIS = 12;
    // Shared 11-bit length field, bits 10:0
    localparam int TBCU_LEN_W = 11;
    localparam int TBCU_TAG_W = 16;
    // ==========================================================
    // End alignment codes and word masks
    localparam logic [1:0] TBCU_AL_4 = 2'h0;
    localparam logic [1:0] TBCU_AL_16 = 2'h1;
    localparam logic [1:0] TBCU_AL_32 = 2'h2;
    localparam logic [3:0] TBCU_MASK_4 = 4'h0;
    localparam logic [3:0] TBCU_MASK_16 = 4'h3;
    localparam logic [3:0] TBCU_MASK_32 = 4'h7;
    localparam logic [1:0] TBCU_LANE_TOP = 2'h3;
    // ==========================================================
    // Buffer parsing states
    typedef enum logic [1:0] {
        TBCU_CMD_A = 2'b00,
        TBCU_CMD_B = 2'b01,
        TBCU_DATA = 2'b10
    } tbcu_state_t;
endpackage

/* File: tbcu_unpacker.sv */
// Transmit buffer command unpacker with Avalon-MM slave port
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
module tbcu_unpacker #(
    parameter int LEN_W = tbcu_pkg::TBCU_LEN_W,
    parameter int TAG_W = tbcu_pkg::TBCU_TAG_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [7:0] mif_data,
    output logic mif_valid,
    input wire logic mif_ready,
    output logic pkt_done,
    output logic [31:0] tx_status_word,
    output logic fcs_append,
    output logic pad_enable,
    output logic transmit_error_flag
);
    // ==========================================================
    // State record
    typedef struct packed {
        tbcu_pkg::tbcu_state_t st;
        logic wait_n;              // Low for one cycle to answer
        logic [31:0] rdata;
        logic first_seg;
        logic last_seg;
        logic [4:0] start_off;
        logic [LEN_W-1:0] buf_left;
        logic [3:0] word_idx;       // Data words taken so far, stops at 15
        logic [9:0] words_total;    // Data words incl. offset, pad
        logic [9:0] words_seen;
        logic [TAG_W-1:0] tag;
        logic crc_dis;
        logic pad_dis;
        logic [LEN_W-1:0] pkt_len;
        logic [LEN_W+1:0] sum;
        logic done_pend;
        logic [31:0] hold;
        logic [1:0] lane;
        logic [1:0] last_lane;
        logic busy;
        logic [7:0] mdata;
        logic mvalid;
        logic done;
        logic [31:0] txst;
        logic fcs;
        logic pad;
        logic err;
    } tbcu_regs_t;

    tbcu_regs_t r_q;
    tbcu_regs_t r_d;

    logic req;
    logic accept;
    logic data_wr;
    logic [LEN_W+1:0] end_byte;
    logic [9:0] raw_words;
    logic [9:0] amask;
    logic [1:0] lane_first;
    logic [LEN_W-1:0] lane_room;
    logic [LEN_W-1:0] take;
    logic [LEN_W+1:0] sum_next;

    // ==========================================================
    // Bus request decode
    assign req = read || write;
    assign data_wr = write && (address == tbcu_pkg::TBCU_ADDR_DATA);
    // Data words wait while the byte emitter still holds a word
    assign accept = req && r_q.wait_n && !(data_wr && r_q.busy);

    // Word count of a buffer rounded up to its end alignment
    assign end_byte = (LEN_W+2)'(writedata[tbcu_pkg::TBCU_A_OFF_LO +: 5])
        + (LEN_W+2)'(writedata[LEN_W-1:0]);
    assign raw_words = 10'((end_byte + (LEN_W+2)'(3)) >> 2);
    always_comb begin
        unique case (writedata[tbcu_pkg::TBCU_A_ALIGN_LO +: 2])
            tbcu_pkg::TBCU_AL_16: amask = 10'(tbcu_pkg::TBCU_MASK_16);
            tbcu_pkg::TBCU_AL_32: amask = 10'(tbcu_pkg::TBCU_MASK_32);
            default: amask = 10'(tbcu_pkg::TBCU_MASK_4);
        endcase
    end

    // First lane of a payload word and bytes it can carry
    always_comb begin
        lane_first = 2'h0;
        if (r_q.word_idx == {1'b0, r_q.start_off[4:2]}) begin
            lane_first = r_q.start_off[1:0];
        end
        lane_room = LEN_W'(3'h4) - LEN_W'(lane_first);
        take = (r_q.buf_left < lane_room) ? r_q.buf_left : lane_room;
    end

    assign sum_next = r_q.sum + (LEN_W+2)'(writedata[LEN_W-1:0]);

    // ==========================================================
    // Next state
    always_comb begin
        r_d = r_q;
        r_d.wait_n = 1'b1;
        r_d.done = 1'b0;

        // Handshake: drop waitrequest one cycle, act on that edge
        if (accept) begin
            r_d.wait_n = 1'b0;
            unique case (address)
                tbcu_pkg::TBCU_ADDR_STAT: begin
                    r_d.rdata = 32'h0;
                    r_d.rdata[tbcu_pkg::TBCU_STAT_ERR] = r_q.err;
                    r_d.rdata[tbcu_pkg::TBCU_STAT_ST_LO +: 2] = r_q.st;
                end
                tbcu_pkg::TBCU_ADDR_TXST: r_d.rdata = r_q.txst;
                tbcu_pkg::TBCU_ADDR_SUM: r_d.rdata = 32'(r_q.sum);
                default: r_d.rdata = 32'h0;  // Data port, unmapped
            endcase
        end

        // Output byte register drains into the media layer
        if (r_q.mvalid && mif_ready) begin
            r_d.mvalid = 1'b0;
        end
        if (r_q.busy && (!r_q.mvalid || mif_ready)) begin
            r_d.mdata = r_q.hold[{r_q.lane, 3'h0} +: 8];
            r_d.mvalid = 1'b1;
            r_d.lane = r_q.lane + 2'h1;
            if (r_q.lane == r_q.last_lane) begin
                r_d.busy = 1'b0;
            end
        end

        // Packet completes after its last byte has left the emitter
        if (r_q.done_pend && !r_q.busy) begin
            r_d.done_pend = 1'b0;
            r_d.done = 1'b1;
            r_d.txst = {r_q.tag, 16'h0};
            r_d.fcs = !r_q.crc_dis || r_q.pad_dis;
            r_d.pad = !r_q.pad_dis;
            if (r_q.sum != (LEN_W+2)'(r_q.pkt_len)) begin
                r_d.err = 1'b1;
            end
        end

        // Status write of one clears the error flag; a new set wins
        if (!r_q.wait_n && write && address == tbcu_pkg::TBCU_ADDR_STAT
            && writedata[tbcu_pkg::TBCU_STAT_ERR] && !r_d.err) begin
            r_d.err = 1'b0;
        end else if (!r_q.wait_n && write
            && address == tbcu_pkg::TBCU_ADDR_STAT
            && writedata[tbcu_pkg::TBCU_STAT_ERR]
            && !(r_q.done_pend && !r_q.busy
            && r_q.sum != (LEN_W+2)'(r_q.pkt_len))) begin
            r_d.err = 1'b0;
        end

        // Word parsing happens at the edge that completes a write
        if (!r_q.wait_n && data_wr) begin
            unique case (r_q.st)
                tbcu_pkg::TBCU_CMD_A: begin
                    r_d.first_seg = writedata[tbcu_pkg::TBCU_A_FS];
                    r_d.last_seg = writedata[tbcu_pkg::TBCU_A_LS];
                    r_d.start_off = writedata[tbcu_pkg::TBCU_A_OFF_LO +: 5];
                    r_d.buf_left = writedata[LEN_W-1:0];
                    r_d.words_total = (raw_words + amask) & ~amask;
                    r_d.words_seen = 10'h0;
                    r_d.word_idx = 4'h0;
                    // Running size sum restarts on a first segment
                    r_d.sum = writedata[tbcu_pkg::TBCU_A_FS]
                        ? (LEN_W+2)'(writedata[LEN_W-1:0]) : sum_next;
                    r_d.st = tbcu_pkg::TBCU_CMD_B;
                end
                tbcu_pkg::TBCU_CMD_B: begin
                    // Kept only for the first segment of a packet
                    if (r_q.first_seg) begin
                        r_d.tag = writedata[tbcu_pkg::TBCU_B_TAG_LO +: TAG_W];
                        r_d.crc_dis = writedata[tbcu_pkg::TBCU_B_CRC_DIS];
                        r_d.pad_dis = writedata[tbcu_pkg::TBCU_B_PAD_DIS];
                        r_d.pkt_len = writedata[LEN_W-1:0];
                    end
                    // Data words begin with the next word unless the buffer has none
                    if (r_q.words_total == 10'h0) begin
                        r_d.st = tbcu_pkg::TBCU_CMD_A;
                        r_d.done_pend = r_q.last_seg;
                    end else begin
                        r_d.st = tbcu_pkg::TBCU_DATA;
                    end
                end
                tbcu_pkg::TBCU_DATA: begin
                    r_d.words_seen = r_q.words_seen + 10'h1;
                    if (r_q.word_idx != 4'hF) begin
                        r_d.word_idx = r_q.word_idx + 4'h1;
                    end
                    // Whole offset words skipped, then payload lanes
                    if (r_q.word_idx >= {1'b0, r_q.start_off[4:2]}
                        && r_q.buf_left != '0) begin
                        r_d.hold = writedata;
                        r_d.lane = lane_first;
                        // Trailing lanes past the count are dropped
                        r_d.last_lane = 2'(lane_first + 2'(take - 1'b1));
                        r_d.busy = 1'b1;
                        r_d.buf_left = r_q.buf_left - take;
                    end
                    // Pad words after the payload are swallowed
                    if (r_q.words_seen + 10'h1 == r_q.words_total) begin
                        r_d.st = tbcu_pkg::TBCU_CMD_A;
                        r_d.done_pend = r_q.last_seg;
                    end
                end
                default: r_d.st = tbcu_pkg::TBCU_CMD_A;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_q <= '0;
            r_q.st <= tbcu_pkg::TBCU_CMD_A;
            r_q.wait_n <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state record
    assign readdata = r_q.rdata;
    assign waitrequest = r_q.wait_n;
    assign mif_data = r_q.mdata;
    assign mif_valid = r_q.mvalid;
    assign pkt_done = r_q.done;
    assign tx_status_word = r_q.txst;
    assign fcs_append = r_q.fcs;
    assign pad_enable = r_q.pad;
    assign transmit_error_flag = r_q.err;
endmodule

/* File: tbcu_monitor.sv */
// Port-level checker of the transmit buffer command unpacker
`timescale 1ns/10ps
module tbcu_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [7:0] mif_data,
    input wire logic mif_valid,
    input wire logic mif_ready,
    input wire logic pkt_done,
    input wire logic [31:0] tx_status_word,
    input wire logic fcs_append,
    input wire logic pad_enable,
    input wire logic transmit_error_flag
);
    // ==========================================================
    // Bus handshake and packet outputs, one clock domain
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_ack_one; !waitrequest |=> waitrequest; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held too long");
    property p_ack_cause; $fell(waitrequest) |-> $past(read || write);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    // Stalls on data words are bounded by the byte emitter
    property p_ack_bound;
        (read || write) && waitrequest |-> ##[1:60] !waitrequest;
    endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("no ack");
    property p_pad_fcs; pkt_done && !pad_enable |-> fcs_append; endproperty
    a_pad_fcs: assert property (p_pad_fcs) else $error("fcs dropped");
    property p_done_pulse; pkt_done |=> !pkt_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("long done");
    property p_mif_hold;
        mif_valid && !mif_ready |=> mif_valid && $stable(mif_data);
    endproperty
    a_mif_hold: assert property (p_mif_hold) else $error("byte lost");
    // Error only clears by an acknowledged one-to-clear write
    property p_err_sticky; transmit_error_flag && !(write && !waitrequest &&
        address == tbcu_pkg::TBCU_ADDR_STAT && writedata[0])
        |=> transmit_error_flag;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error lost");
    property p_err_rise; $rose(transmit_error_flag) |-> pkt_done; endproperty
    a_err_rise: assert property (p_err_rise) else $error("error early");
    property p_st_chg; $changed(tx_status_word) |-> pkt_done; endproperty
    a_st_chg: assert property (p_st_chg) else $error("status moved");
    c_err: cover property ($rose(transmit_error_flag));
    c_stall: cover property (mif_valid && !mif_ready);
    c_nopad: cover property (pkt_done && !pad_enable);
endmodule

/* File: tbcu_host_model.sv */
// Host processor model writing transmit buffers over Avalon-MM
`timescale 1ns/10ps
module tbcu_host_model (
    input wire logic clk,
    output logic [3:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    initial begin
        address = 4'h0; read = 1'b0; write = 1'b0; writedata = 32'h0;
    end
    // One transfer, held until waitrequest is sampled low
    task automatic xfer(input logic rd, input logic [3:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        address <= a; writedata <= d; read <= rd; write <= !rd;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0; write <= 1'b0;
    endtask
    // Packets stay far below 2036 FIFO bytes and 86 buffers
    task automatic send_buf(input logic [15:0] tag, input logic [1:0] fl,
        input logic [4:0] off, input logic [1:0] al, input int size,
        input int len, input logic [1:0] cp, input logic [7:0] b0);
        logic [31:0] w, q;
        int nw, p, ab;
        ab = (al == 2'h0) ? 4 : (al == 2'h1) ? 16 : 32;
        nw = ((off + size + ab - 1) / ab) * ab / 4;
        xfer(0, 4'h0, {6'h0, al, 3'h0, off, 2'h0, fl, 1'b0, 11'(size)}, q);
        xfer(0, 4'h0, {tag, 2'h0, cp, 1'b0, 11'(len)}, q);
        for (int k = 0; k < nw; k++) begin
            for (int l = 0; l < 4; l++) begin
                p = k * 4 + l - off;
                w[8*l+:8] = (p >= 0 && p < size) ? b0 + 8'(p) : 8'hC3 ^ 8'(k);
            end
            xfer(0, 4'h0, w, q);
        end
    endtask
endmodule

/* File: tbcu_unpacker_tb.sv */
// Self-checking testbench of the transmit buffer command unpacker
`timescale 1ns/10ps
module tbcu_unpacker_tb;
    logic clk = 0, nrst = 0, mif_ready = 1, stall = 0;
    logic read, write, waitrequest, mif_valid, pkt_done;
    logic fcs_append, pad_enable, transmit_error_flag;
    logic [3:0] address;
    logic [31:0] writedata, readdata, tx_status_word, q;
    logic [7:0] mif_data;
    logic [7:0] got[$];
    logic [31:0] st_seen;
    logic fcs_seen, pad_seen, err_seen;
    int failures = 0, n_tests = 0, n_done = 0;
    always #25 clk = !clk;
    tbcu_unpacker dut (.clk(clk), .nrst(nrst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .mif_data(mif_data),
        .mif_valid(mif_valid), .mif_ready(mif_ready), .pkt_done(pkt_done),
        .tx_status_word(tx_status_word), .fcs_append(fcs_append),
        .pad_enable(pad_enable), .transmit_error_flag(transmit_error_flag));
    tbcu_host_model host (.clk(clk), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest));
    // ==========================================================
    // Media side: toggling ready stalls the emitter mid-word
    always @(posedge clk) begin
        mif_ready <= stall ? !mif_ready : 1'b1;
        if (mif_valid === 1'b1 && mif_ready === 1'b1) got.push_back(mif_data);
        if (pkt_done === 1'b1) begin
            n_done++; st_seen = tx_status_word; fcs_seen = fcs_append;
            pad_seen = pad_enable; err_seen = transmit_error_flag;
        end
    end
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bytes(input logic [7:0] b0, input int n);
        cmp("byte count", n, got.size());
        for (int i = 0; i < n && i < got.size(); i++) begin
            cmp("byte", b0 + 8'(i), got[i]);
        end
        got.delete();
    endtask
    task automatic chk_pkt(input int t, input logic [31:0] st,
                           input logic [2:0] fpe);
        for (int i = 0; i < 400 && n_done < t; i++) @(negedge clk);
        cmp("packets", t, n_done);
        cmp("status word", st, st_seen);
        cmp("fcs pad err", fpe, {fcs_seen, pad_seen, err_seen});
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        cmp("reset outs", 3'b100, {waitrequest, mif_valid, transmit_error_flag});
        host.xfer(1, 4'h1, 0, q); cmp("unmapped", 0, q);
        host.xfer(0, tbcu_pkg::TBCU_ADDR_TXST, 32'h5A5A5A5A, q);
        host.xfer(1, tbcu_pkg::TBCU_ADDR_TXST, 0, q); cmp("txst ro", 0, q);
    endtask
    task automatic t_single();
        host.send_buf(16'hBEEF, 2'b11, 5'd2, 2'h0, 5, 5, 2'b10, 8'h10);
        chk_pkt(1, 32'hBEEF0000, 3'b010);
        chk_bytes(8'h10, 5);
        host.xfer(1, tbcu_pkg::TBCU_ADDR_TXST, 0, q); cmp("txst", 32'hBEEF0000, q);
    endtask
    // Word skips, 16/32-byte padding, later command words ignored
    task automatic t_multi();
        stall = 1;
        host.send_buf(16'h1234, 2'b10, 5'd7, 2'h1, 3, 9, 2'b11, 8'h20);
        host.send_buf(16'hFFFF, 2'b00, 5'd0, 2'h2, 4, 1, 2'b00, 8'h23);
        host.send_buf(16'hFFFF, 2'b01, 5'd10, 2'h2, 2, 1, 2'b00, 8'h27);
        chk_pkt(2, 32'h12340000, 3'b100);
        chk_bytes(8'h20, 9);
        stall = 0;
    endtask
    task automatic t_mismatch();
        host.send_buf(16'h00A5, 2'b11, 5'd1, 2'h0, 5, 6, 2'b00, 8'h40);
        chk_pkt(3, 32'h00A50000, 3'b111);
        chk_bytes(8'h40, 5);
        host.xfer(1, tbcu_pkg::TBCU_ADDR_STAT, 0, q); cmp("stat", 32'h1, q);
        host.send_buf(16'h0042, 2'b11, 5'd3, 2'h0, 3, 3, 2'b00, 8'h50);
        chk_pkt(4, 32'h00420000, 3'b111);
        chk_bytes(8'h50, 3);
        host.xfer(0, tbcu_pkg::TBCU_ADDR_STAT, 32'h1, q);
        host.xfer(1, tbcu_pkg::TBCU_ADDR_STAT, 0, q); cmp("stat clr", 0, q);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        t_reset();
        t_single();
        t_multi();
        t_mismatch();
        end_of_test();
    end
    initial begin
        #1000000;
        failures++;
        end_of_test();
    end
endmodule
bind tbcu_unpacker tbcu_monitor mon (.clk(clk), .nrst(nrst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .mif_data(mif_data),
    .mif_valid(mif_valid), .mif_ready(mif_ready), .pkt_done(pkt_done),
    .tx_status_word(tx_status_word), .fcs_append(fcs_append),
    .pad_enable(pad_enable), .transmit_error_flag(transmit_error_flag));
